// ===== bench/rsc_asserts.sv
// Port-level checker for the reset source control block
`timescale 1ns/1ps
`default_nettype none
module rsc_asserts
#(
	parameter NUM_PERIPH = 32
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic powerUpDetect,
	input wire logic pinResetN,
	input wire logic wdogTimeoutSecond,
	input wire logic wdogResetEnable,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic coreResetN,
	input wire logic periphResetN,
	input wire logic testPortResetN,
	input wire logic testPinCfgResetN,
	input wire logic [NUM_PERIPH-1:0] periphSoftResetN
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_pin_core: assert property (!pinResetN |-> ##[0:3] !coreResetN)
		else $error("pin reset did not reach core");
	a_pin_cfg: assert property (!pinResetN |-> ##[0:3] !testPinCfgResetN)
		else $error("pin reset did not reach test pin setup");
	a_tap_kept: assert property (!powerUpDetect [*4] |-> testPortResetN)
		else $error("test port reset without power-up");
	a_core_peri: assert property (coreResetN == periphResetN)
		else $error("core and peripheral resets differ");
	a_soft_all: assert property (!periphResetN |=> periphSoftResetN == {NUM_PERIPH{1'b0}})
		else $error("peripheral reset did not reach every peripheral");
	a_wdog_rst: assert property (wdogTimeoutSecond && wdogResetEnable |-> ##[0:3] !coreResetN)
		else $error("watchdog reset missing");
	a_rel_clean: assert property ($rose(coreResetN) |-> $past(pinResetN, 2) && !$past(powerUpDetect, 2))
		else $error("core released while a source was active");
	a_soft_pulse: assert property ($fell(periphSoftResetN[0]) && periphResetN |=> periphSoftResetN[0])
		else $error("peripheral soft reset longer than one cycle");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid |-> ##[1:4] s_axi_bvalid)
		else $error("write answer late");
endmodule
bind rsc_reset_source_control rsc_asserts #(.NUM_PERIPH(NUM_PERIPH)) rsc_asserts_inst (.*);
`default_nettype wire

// ===== bench/rsc_board_model.sv
// Board side: reset pin driver with minimum pulse and grounded test-mode pins
`timescale 1ns/1ps
`default_nettype none
module rsc_board_model
#(
	parameter int MIN_PULSE = 4
)
(
	input wire logic core_clk,
	input wire logic pinReq,
	output logic pinResetN,
	output logic test_mode_in0,
	output logic test_mode_in1
);
	int cnt = 0;
	initial pinResetN = 1'b1;
	assign test_mode_in0 = 1'b0;
	assign test_mode_in1 = 1'b0;
	// Short requests are stretched so the pin never breaks the minimum width
	always @(posedge core_clk)
	begin
		cnt <= pinReq ? MIN_PULSE : (cnt > 0 ? cnt - 1 : 0);
		pinResetN <= !(pinReq || cnt > 1);
	end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the reset source control block
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.vh"
module tb;
	logic core_clk, reset_n, powerUpDetect, pinReq, supplyDroop, pinResetN;
	logic wdogTimeoutSecond, wdogResetEnable, test_mode_in0, test_mode_in1;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat, seen, mask;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rres, wres;
	logic coreResetN, periphResetN, testPortResetN, testPinCfgResetN, nmiFunctionSel, clr;
	logic [31:0] periphSoftResetN;
	int n_errors = 0, checks = 0, cause = 2, cyc = 0;
	rsc_reset_source_control rsc_reset_source_control_inst (.*);
	rsc_board_model rsc_board_model_inst (.*);
	initial
	begin
		core_clk = 0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		seen <= clr ? 32'h0 : seen | ~periphSoftResetN;
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// ----------------------------------------
	// Bus master tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw = 1;
		bit w = 1;
		@(posedge core_clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		while (aw || w)
		begin
			@(posedge core_clk);
			if (s_axi_awready) aw = 0;
			if (s_axi_wready) w = 0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		while (!s_axi_bvalid) @(posedge core_clk);
		wres = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		s_axi_araddr <= {24'h0, a};
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid) @(posedge core_clk);
		rdat = s_axi_rdata;
		rres = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rdat, e);
	endtask
	// Source k: 0 watchdog, 1 droop, 2 pin; en gates the first two
	task automatic src(input int k, input bit en);
		if (k == 1) wr(`RSC_OFF_SUPPLY_CTL, {30'h0, en, 1'b0});
		@(posedge core_clk);
		wdogResetEnable <= en;
		wdogTimeoutSecond <= (k == 0);
		supplyDroop <= (k == 1);
		pinReq <= (k == 2);
		repeat (6) @(posedge core_clk);
		chk(coreResetN, !(en || k == 2));
		chk(periphResetN, !(en || k == 2));
		chk(testPinCfgResetN, k != 2);
		chk(testPortResetN, 1'b1);
		{wdogTimeoutSecond, supplyDroop, pinReq} <= 3'h0;
		repeat (12) @(posedge core_clk);
		chk(coreResetN, 1'b1);
		chk(testPinCfgResetN, 1'b1);
		if (en || k == 2) cause = k == 2 ? 1 : cause | (k == 0 ? 8 : 4);
		rdc(`RSC_OFF_CAUSE, cause);
	endtask
	task automatic report_and_stop;
		$display("Checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{reset_n, pinReq, supplyDroop, wdogTimeoutSecond, wdogResetEnable} = 5'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		powerUpDetect = 1;
		clr = 1;
		void'($urandom(98819));
		repeat (16) @(posedge core_clk);
		reset_n <= 1;
		powerUpDetect <= 0;
		repeat (6) @(posedge core_clk);
		chk({coreResetN, testPortResetN, nmiFunctionSel}, 3'h6);
		rdc(`RSC_OFF_CAUSE, cause);
		rdc(`RSC_OFF_IDENT0, `RSC_IDENT0_VAL);
		rdc(`RSC_OFF_IDENT1, `RSC_IDENT1_VAL);
		rd(`RSC_OFF_STATUS);
		chk(rdat & 32'hC, 32'h0);
		chk(rdat[1:0], 2'h3);
		rd(8'h20);
		chk(rres, `RSC_RESP_SLVERR);
		wr(8'h20, 32'h0);
		chk(wres, `RSC_RESP_SLVERR);
		for (int k = 0; k < 3; k++)
		begin
			src(k, 0);
			src(k, 1);
		end
		wr(`RSC_OFF_CORE_IRQ_RST, 32'h4);
		@(posedge core_clk);
		chk(coreResetN, 1'b0);
		repeat (20) @(posedge core_clk);
		cause = cause | 16;
		rdc(`RSC_OFF_CAUSE, cause);
		mask = $urandom() | 32'h1;
		clr <= 0;
		wr(`RSC_OFF_PERIPH_RST, mask);
		wr(`RSC_OFF_PERIPH_RST, 32'h0);
		repeat (3) @(posedge core_clk);
		chk(seen, mask);
		wr(`RSC_OFF_PIN_ALT, 32'h1);
		@(posedge core_clk);
		chk(nmiFunctionSel, 1'b1);
		chk(wres, `RSC_RESP_OKAY);
		report_and_stop;
	end
endmodule
`default_nettype wire

// ===== hdl/rsc_regs.vh
// Register offsets, field positions and reset values of the reset source control block
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
`define RSC_ADDR_W 8
`define RSC_OFF_CAUSE 8'h00
`define RSC_OFF_SUPPLY_CTL 8'h04
`define RSC_OFF_CORE_IRQ_RST 8'h08
`define RSC_OFF_PERIPH_RST 8'h0C
`define RSC_OFF_PIN_ALT 8'h10
`define RSC_OFF_IDENT0 8'h14
`define RSC_OFF_IDENT1 8'h18
`define RSC_OFF_STATUS 8'h1C
`define RSC_CAUSE_EXT 0
`define RSC_CAUSE_POR 1
`define RSC_CAUSE_DROOP 2
`define RSC_CAUSE_WDOG 3
`define RSC_CAUSE_SW 4
`define RSC_DROOP_EN_BIT 1
`define RSC_SYSRST_REQ_BIT 2
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2
`define RSC_RESET_STRETCH 4'h8
`define RSC_IDENT0_VAL 32'h00010000
`define RSC_IDENT1_VAL 32'h00000001
`endif

// ===== hdl/rsc_reset_source_control.v
// Reset source control: reset gathering, cause flags, soft resets and AXI4-Lite registers
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.vh"
// How it works
// - Five sources: pin reset, power-up, supply droop, software and watchdog.
// - Power-up resets core, peripherals and test port controller.
// - Pin reset resets core and peripherals; test port only gets pin setup reset.
// - Droop, soft system and watchdog skip test port; peripheral soft reset skips core.
// - Each peripheral has its own software reset bit.
// - Writing the system reset request bit starts a whole-system reset.
// - After a reset the flag of its source is set.
// - Cause flags are sticky across later droop, software and watchdog resets.
// - Power-up or pin reset clears all other cause flags.
// - Internal reset held until power-up detector deasserts; then core fetches vectors.
// - Power-up detector acts only on first power-up.
// - Pin reset held minimum time by outside; after release core starts.
// - Interrupt pin acts as GPIO until its alternate function bit is set.
// - Read-only identification words report version, part and memory sizes.
// - Droop resets only when enabled, held until supply recovers.
// - Set then clear of a peripheral bit resets that peripheral.
// - Watchdog second time-out resets the system if its reset output is enabled.
module rsc_reset_source_control
#(
	parameter NUM_PERIPH = 32,
	parameter [31:0] IDENT0 = `RSC_IDENT0_VAL,
	parameter [31:0] IDENT1 = `RSC_IDENT1_VAL
)
(
	input wire core_clk,
	input wire reset_n,
	input wire powerUpDetect,
	input wire pinResetN,
	input wire supplyDroop,
	input wire wdogTimeoutSecond,
	input wire wdogResetEnable,
	input wire test_mode_in0,
	input wire test_mode_in1,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	output reg [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	input wire [31:0] s_axi_araddr,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg coreResetN,
	output reg periphResetN,
	output reg testPortResetN,
	output reg testPinCfgResetN,
	output reg [NUM_PERIPH-1:0] periphSoftResetN,
	output reg nmiFunctionSel
);
	// ------------------------------------------------------------
	// Reset gathering
	// ------------------------------------------------------------
	// Power-up detector is only active on first ramp, so it alone touches the test port
	wire porActive = powerUpDetect | ~reset_n;
	wire extActive = ~pinResetN;
	reg droopEnReg;
	reg sysReqReg;
	reg [3:0] stretchReg;
	wire droopActive = supplyDroop & droopEnReg;
	wire wdogActive = wdogTimeoutSecond & wdogResetEnable;
	wire sysActive = sysReqReg | (stretchReg != 4'h0);
	// Glitches on these combined terms can only lengthen a reset, never shorten it
	wire anyCoreReq = porActive | extActive | droopActive | wdogActive | sysActive;
	wire porRelN;
	wire coreRelN;
	rsc_sync porSync
	(
		.core_clk(core_clk),
		.reqActive(porActive),
		.releasedN(porRelN)
	);
	rsc_sync coreSync
	(
		.core_clk(core_clk),
		.reqActive(anyCoreReq),
		.releasedN(coreRelN)
	);

	// Outputs registered; core fetches vectors after coreResetN rises
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			coreResetN <= 1'b0;
			periphResetN <= 1'b0;
			testPortResetN <= 1'b0;
			testPinCfgResetN <= 1'b0;
		end
		else
		begin
			coreResetN <= coreRelN;
			periphResetN <= coreRelN;
			testPortResetN <= porRelN;
			testPinCfgResetN <= porRelN & ~extActive;
		end
	end

	// ------------------------------------------------------------
	// Cause flags
	// ------------------------------------------------------------
	// These live on the always-on domain: only power-up and pin reset clear them
	reg [4:0] causeReg;
	reg [4:0] causeNext;
	always @*
	begin
		causeNext = causeReg;
		if (droopActive)
			causeNext[`RSC_CAUSE_DROOP] = 1'b1;
		if (wdogActive)
			causeNext[`RSC_CAUSE_WDOG] = 1'b1;
		if (sysActive)
			causeNext[`RSC_CAUSE_SW] = 1'b1;
		if (extActive)
		begin
			causeNext = 5'h00;
			causeNext[`RSC_CAUSE_EXT] = 1'b1;
		end
	end

	always @(posedge core_clk or posedge porActive)
	begin
		if (porActive)
			causeReg <= 5'h02;
		else
			causeReg <= causeNext;
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	reg awHeldReg;
	reg wHeldReg;
	reg [7:0] awAddrReg;
	reg [31:0] wDataReg;
	reg [3:0] wStrbReg;
	reg [NUM_PERIPH-1:0] periphRstReg;
	reg [NUM_PERIPH-1:0] periphPrevReg;
	reg [31:0] readVal;
	reg readOk;
	wire doWrite = awHeldReg & wHeldReg & ~s_axi_bvalid;
	wire [7:0] rdAddr = s_axi_araddr[7:0];

	// One address map for both directions, so reads and writes agree on what exists
	function rsc_mapped;
		input [7:0] addr;
		begin
			case (addr)
				`RSC_OFF_CAUSE, `RSC_OFF_SUPPLY_CTL, `RSC_OFF_CORE_IRQ_RST, `RSC_OFF_PERIPH_RST,
				`RSC_OFF_PIN_ALT, `RSC_OFF_IDENT0, `RSC_OFF_IDENT1, `RSC_OFF_STATUS:
					rsc_mapped = 1'b1;
				default: rsc_mapped = 1'b0;
			endcase
		end
	endfunction

	// Pads peripheral bits to a bus word; holds at most 32 peripherals
	function [31:0] rsc_periph_word;
		input [NUM_PERIPH-1:0] bits;
		integer i;
		begin
			rsc_periph_word = 32'h00000000;
			for (i = 0; i < NUM_PERIPH; i = i + 1)
				rsc_periph_word[i] = bits[i];
		end
	endfunction

	function [31:0] rsc_merge;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0] strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				rsc_merge[i*8 +: 8] = strb[i] ? newVal[i*8 +: 8] : oldVal[i*8 +: 8];
		end
	endfunction

	wire [31:0] mergedPeriph = rsc_merge(rsc_periph_word(periphRstReg), wDataReg, wStrbReg);

	always @*
	begin
		readOk = rsc_mapped(rdAddr);
		readVal = 32'h00000000;
		case (rdAddr)
			`RSC_OFF_CAUSE: readVal = {27'h0, causeReg};
			`RSC_OFF_SUPPLY_CTL: readVal = {30'h0, droopEnReg, 1'b0};
			`RSC_OFF_CORE_IRQ_RST: readVal = 32'h00000000;
			`RSC_OFF_PERIPH_RST: readVal = rsc_periph_word(periphRstReg);
			`RSC_OFF_PIN_ALT: readVal = {31'h0, nmiFunctionSel};
			`RSC_OFF_IDENT0: readVal = IDENT0;
			`RSC_OFF_IDENT1: readVal = IDENT1;
			`RSC_OFF_STATUS: readVal = {28'h0, test_mode_in1, test_mode_in0, porRelN, coreRelN};
			default: readVal = 32'h00000000;
		endcase
	end

	// Bus and control registers are reset by reset_n alone, not by peripheral reset
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RSC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RSC_RESP_OKAY;
			awHeldReg <= 1'b0;
			wHeldReg <= 1'b0;
			awAddrReg <= 8'h00;
			wDataReg <= 32'h00000000;
			wStrbReg <= 4'h0;
			droopEnReg <= 1'b0;
			sysReqReg <= 1'b0;
			stretchReg <= 4'h0;
			periphRstReg <= {NUM_PERIPH{1'b0}};
			periphPrevReg <= {NUM_PERIPH{1'b0}};
			periphSoftResetN <= {NUM_PERIPH{1'b0}};
			nmiFunctionSel <= 1'b0;
		end
		else
		begin
			s_axi_awready <= ~awHeldReg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~wHeldReg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready)
			begin
				awHeldReg <= 1'b1;
				awAddrReg <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				wHeldReg <= 1'b1;
				wDataReg <= s_axi_wdata;
				wStrbReg <= s_axi_wstrb;
			end
			if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// System request pulse is stretched so the request outlives the sync release
			if (sysReqReg)
				stretchReg <= `RSC_RESET_STRETCH;
			else if (stretchReg != 4'h0)
				stretchReg <= stretchReg - 4'h1;
			sysReqReg <= 1'b0;
			if (doWrite)
			begin
				awHeldReg <= 1'b0;
				wHeldReg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= rsc_mapped(awAddrReg) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
				case (awAddrReg)
					`RSC_OFF_CAUSE: ;
					`RSC_OFF_SUPPLY_CTL:
						if (wStrbReg[0])
							droopEnReg <= wDataReg[`RSC_DROOP_EN_BIT];
					`RSC_OFF_CORE_IRQ_RST:
						if (wStrbReg[0] & wDataReg[`RSC_SYSRST_REQ_BIT])
							sysReqReg <= 1'b1;
					`RSC_OFF_PERIPH_RST:
						periphRstReg <= mergedPeriph[NUM_PERIPH-1:0];
					`RSC_OFF_PIN_ALT:
						if (wStrbReg[0])
							nmiFunctionSel <= wDataReg[0];
					`RSC_OFF_IDENT0: ;
					`RSC_OFF_IDENT1: ;
					`RSC_OFF_STATUS: ;
					default: ;
				endcase
			end
			// Peripheral pulse on falling control bit; whole-system reset also hits all
			periphPrevReg <= periphRstReg;
			periphSoftResetN <= ~(periphPrevReg & ~periphRstReg) & {NUM_PERIPH{periphResetN}};
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readVal;
				s_axi_rresp <= readOk ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/rsc_sync.v
// Reset request synchroniser: async assert, clean release on a clock edge
`timescale 1ns/1ps
`default_nettype none
module rsc_sync
(
	input wire core_clk,
	input wire reqActive,
	output reg releasedN
);
	reg stage1Reg;
	always @(posedge core_clk or posedge reqActive)
	begin
		if (reqActive)
		begin
			stage1Reg <= 1'b0;
			releasedN <= 1'b0;
		end
		else
		begin
			stage1Reg <= 1'b1;
			releasedN <= stage1Reg;
		end
	end
endmodule
`default_nettype wire
